/* verilog/rf_timer_pkg.sv */
// Package for the reader protocol timer block: register map, fields, defaults.
// Assumes a byte-wide register file reached over Avalon-MM, one word per register.
`default_nettype none
package rf_timer_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_RX_MASK_TIME  = 8'h0e;
    localparam logic [7:0] IDX_RESP_HIGH     = 8'h0f;
    localparam logic [7:0] IDX_RESP_LOW      = 8'h10;
    localparam logic [7:0] IDX_TIMER_CONTROL = 8'h11;
    localparam logic [7:0] IDX_GEN_HIGH      = 8'h12;
    localparam logic [7:0] IDX_GEN_LOW       = 8'h13;
    localparam logic [7:0] IDX_COMMAND       = 8'h18;
    localparam logic [7:0] IDX_MODE          = 8'h19;
    localparam logic [7:0] IDX_STATUS        = 8'h1a;
    localparam logic [7:0] IDX_IRQ_MASK      = 8'h1b;
    // Reset values
    localparam logic [7:0] RST_RX_MASK_TIME  = 8'h08;
    localparam logic [7:0] RST_ZERO          = 8'h00;
    // Field positions
    localparam int CTL_STEP_BIT  = 0;
    localparam int CTL_EMV_BIT   = 1;
    localparam int CTL_TRIG_LSB  = 5;
    localparam int MODE_NFC_BIT  = 0;
    localparam int MODE_ACT_BIT  = 1;
    localparam int MODE_BRD_BIT  = 2;
    localparam int MODE_TYPEA_BIT = 3;
    localparam int MODE_SQ_BIT   = 4;
    localparam int MASK_RESP_BIT = 6;
    localparam int MASK_GEN_BIT  = 5;
    localparam int STAT_TIM_BIT  = 1;
    // Command codes written to the command register
    localparam logic [7:0] CMD_SET_DEFAULT = 8'h01;
    localparam logic [7:0] CMD_START_RESP  = 8'h02;
    localparam logic [7:0] CMD_START_GEN   = 8'h03;
    // Timing in carrier periods; FC_MASK_MIN counts mask steps, FC_MASK_BRD is a step factor
    localparam int FC_MASK_STEP   = 64;
    localparam int FC_MASK_MIN    = 4;
    localparam int FC_MASK_BRD    = 8;
    localparam int FC_RESP_SHORT  = 64;
    localparam int FC_RESP_LONG   = 4096;
    localparam int FC_GEN_STEP    = 8;
    localparam int SQ_DELAY_FC    = 256;
    // Trigger codes
    typedef enum logic [2:0] {TRIG_NONE, TRIG_RX_END, TRIG_RX_START, TRIG_TX_END_NFC} trig_t;
    // Framing events, one-cycle pulses; rx_raw is the receiver level
    typedef struct packed {
        logic tx_end;
        logic rx_start;
        logic rx_end;
        logic ext_field;
        logic rx_raw;
    } frame_ev_t;
endpackage
`default_nettype wire

/* verilog/step_counter.sv */
// Down counter ticking on a step enable; reports expiry as a one-cycle pulse.
// Assumes start and stop are synchronous single-cycle controls.
`default_nettype none
module step_counter #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Control
    input  wire logic             start,
    input  wire logic             stop,
    input  wire logic             step,
    input  wire logic [WIDTH-1:0] load,
    // Status
    output logic                  running,
    output logic                  expired
);
    logic [WIDTH-1:0] count;
    wire              last_step = running && step && (count <= WIDTH'(1));

    // Start wins over stop so a restart in the same cycle is kept
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count   <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= last_step && !start && !stop;
            if (start) begin
                count   <= load;
                running <= 1'b1;
            end else if (stop || last_step) begin
                running <= 1'b0;
            end else if (running && step) begin
                count <= count - WIDTH'(1);
            end
        end
    end
endmodule
`default_nettype wire

/* verilog/rf_protocol_timers.sv */
// Protocol timers of the reader: receive mask, response timeout, general timer.
// Assumes fc_tick pulses once per carrier period, framing events are clk-domain pulses.
`default_nettype none
module rf_protocol_timers (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    // Carrier tick and framing events
    input  wire logic                      fc_tick,
    input  wire rf_timer_pkg::frame_ev_t   frame_ev,
    // Avalon-MM slave
    input  wire logic [9:0]                avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic [31:0]                    avs_readdata,
    output logic                           avs_waitrequest,
    // Outputs to receiver and field driver
    output logic                           rx_event,
    output logic                           squelch_on,
    output logic                           field_off,
    output logic                           resp_expired,
    output logic                           gen_expired,
    output logic                           timer_irq
);
    // Registers
    logic [7:0] rx_mask_time;
    logic [7:0] response_timeout_high;
    logic [7:0] response_timeout_low;
    logic [7:0] timer_control;
    logic [7:0] general_timeout_high;
    logic [7:0] general_timeout_low;
    logic [7:0] mode;
    logic [7:0] irq_mask;
    logic       stat_resp;
    logic       stat_gen;
    logic       answered;

    // Bus decode: one wait cycle per access so read data come from a flop
    wire [7:0] idx       = avs_address[9:2];
    wire       aligned   = avs_address[1:0] == 2'b00;
    wire       wr_go     = avs_write && !avs_waitrequest && aligned && avs_byteenable[0];
    wire       rd_go     = avs_read && !avs_waitrequest;
    wire [7:0] wdat      = avs_writedata[7:0];
    wire       cmd_wr    = wr_go && idx == rf_timer_pkg::IDX_COMMAND;
    wire       set_def   = cmd_wr && wdat == rf_timer_pkg::CMD_SET_DEFAULT;
    wire       cmd_resp  = cmd_wr && wdat == rf_timer_pkg::CMD_START_RESP;
    wire       cmd_gen   = cmd_wr && wdat == rf_timer_pkg::CMD_START_GEN;
    wire       stat_rd   = rd_go && idx == rf_timer_pkg::IDX_STATUS;

    assign avs_waitrequest = (avs_read || avs_write) && !answered;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            answered <= 1'b0;
        end else begin
            answered <= (avs_read || avs_write) && !answered;
        end
    end

    // Mode and trigger decode
    wire        nfc_mode   = mode[rf_timer_pkg::MODE_NFC_BIT];
    wire        act_mode   = mode[rf_timer_pkg::MODE_ACT_BIT];
    wire        brd_mode   = mode[rf_timer_pkg::MODE_BRD_BIT];
    wire        typea_mode = mode[rf_timer_pkg::MODE_TYPEA_BIT];
    wire        sq_auto    = mode[rf_timer_pkg::MODE_SQ_BIT];
    wire        resp_long  = timer_control[rf_timer_pkg::CTL_STEP_BIT];
    wire        emv_mode   = timer_control[rf_timer_pkg::CTL_EMV_BIT];
    wire [2:0]  trig_code  = timer_control[rf_timer_pkg::CTL_TRIG_LSB +: 3];
    wire [15:0] resp_load  = {response_timeout_high, response_timeout_low};
    wire [15:0] gen_load   = {general_timeout_high, general_timeout_low};

    // Register writes; set-default reloads every register except mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n || 1'b0) begin
            rx_mask_time          <= rf_timer_pkg::RST_RX_MASK_TIME;
            response_timeout_high <= rf_timer_pkg::RST_ZERO;
            response_timeout_low  <= rf_timer_pkg::RST_ZERO;
            timer_control         <= rf_timer_pkg::RST_ZERO;
            general_timeout_high  <= rf_timer_pkg::RST_ZERO;
            general_timeout_low   <= rf_timer_pkg::RST_ZERO;
            mode                  <= rf_timer_pkg::RST_ZERO;
            irq_mask              <= rf_timer_pkg::RST_ZERO;
        end else if (set_def) begin
            rx_mask_time          <= rf_timer_pkg::RST_RX_MASK_TIME;
            response_timeout_high <= rf_timer_pkg::RST_ZERO;
            response_timeout_low  <= rf_timer_pkg::RST_ZERO;
            timer_control         <= rf_timer_pkg::RST_ZERO;
            general_timeout_high  <= rf_timer_pkg::RST_ZERO;
            general_timeout_low   <= rf_timer_pkg::RST_ZERO;
            irq_mask              <= rf_timer_pkg::RST_ZERO;
        end else if (wr_go) begin
            case (idx)
                rf_timer_pkg::IDX_RX_MASK_TIME:  rx_mask_time <= wdat;
                rf_timer_pkg::IDX_RESP_HIGH:     response_timeout_high <= wdat;
                rf_timer_pkg::IDX_RESP_LOW:      response_timeout_low <= wdat;
                rf_timer_pkg::IDX_TIMER_CONTROL: timer_control <= {wdat[7:5], 3'h0, wdat[1:0]};
                rf_timer_pkg::IDX_GEN_HIGH:      general_timeout_high <= wdat;
                rf_timer_pkg::IDX_GEN_LOW:       general_timeout_low <= wdat;
                rf_timer_pkg::IDX_MODE:          mode <= {3'h0, wdat[4:0]};
                rf_timer_pkg::IDX_IRQ_MASK:      irq_mask <= wdat;
                default: ;
            endcase
        end
    end

    // Prescalers on the carrier tick; one shared free counter keeps it small
    logic [11:0] fc_div;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fc_div <= '0;
        end else if (fc_tick) begin
            fc_div <= fc_div + 12'h001;
        end
    end

    // Step pulse when the low bits of the divider wrap for a given step size
    function automatic logic step_of(input logic [11:0] div, input int fc_per_step, input logic tick);
        logic [11:0] lim;
        lim = 12'(fc_per_step - 1);
        step_of = tick && ((div & lim) == lim);
    endfunction

    // Mask timer: 64 fc steps, 512 fc in bit rate detection mode; Type A counts half-steps outside that mode
    wire        mask_step_n  = step_of(fc_div, rf_timer_pkg::FC_MASK_STEP, fc_tick);
    wire        mask_step_b  = step_of(fc_div, rf_timer_pkg::FC_MASK_STEP * rf_timer_pkg::FC_MASK_BRD, fc_tick);
    wire        mask_step_h  = step_of(fc_div, rf_timer_pkg::FC_MASK_STEP / 2, fc_tick);
    wire        mask_step    = brd_mode ? mask_step_b : (typea_mode ? mask_step_h : mask_step_n);
    wire [7:0]  mask_floor   = 8'(rf_timer_pkg::FC_MASK_MIN);
    wire [7:0]  mask_load    = (rx_mask_time <= mask_floor) ? mask_floor : rx_mask_time;
    logic       mask_running;
    logic       mask_done;

    step_counter #(.WIDTH(8)) u_mask (
        .clk     (clk),
        .reset_n (reset_n),
        .start   (frame_ev.tx_end),
        .stop    (set_def),
        .step    (mask_step),
        .load    (mask_load),
        .running (mask_running),
        .expired (mask_done)
    );

    // Receiver output passes only outside the mask interval
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_event <= 1'b0;
        end else begin
            rx_event <= frame_ev.rx_raw && !mask_running && !frame_ev.tx_end;
        end
    end

    // Auto squelch: delayed start after transmit, ends when mask expires
    logic [8:0] sq_wait;
    logic       sq_arm;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sq_wait    <= '0;
            sq_arm     <= 1'b0;
            squelch_on <= 1'b0;
        end else if (frame_ev.tx_end && sq_auto) begin
            sq_wait    <= '0;
            sq_arm     <= 1'b1;
            squelch_on <= 1'b0;
        end else if (!mask_running || !sq_auto) begin
            sq_arm     <= 1'b0;
            squelch_on <= 1'b0;
        end else if (sq_arm && fc_tick) begin
            sq_wait <= sq_wait + 9'h001;
            if (sq_wait == 9'(rf_timer_pkg::SQ_DELAY_FC - 1)) begin
                sq_arm     <= 1'b0;
                squelch_on <= 1'b1;
            end
        end
    end

    // Response timer; NFC mode with the active bit clear holds a pending start until the field appears
    logic pend_field;
    wire  resp_zero   = resp_load == 16'h0000;
    wire  resp_trig   = frame_ev.tx_end && !resp_zero;
    wire  field_now   = frame_ev.ext_field;
    wire  resp_start  = !resp_zero && (cmd_resp
                        || (resp_trig && (!nfc_mode || act_mode || field_now))
                        || (pend_field && field_now));
    wire  resp_step   = step_of(fc_div, resp_long ? rf_timer_pkg::FC_RESP_LONG : rf_timer_pkg::FC_RESP_SHORT,
                                fc_tick);
    // EMV mode: a reply seen during the mask window does not stop the timeout
    wire  resp_stop   = set_def || (frame_ev.rx_start && !(emv_mode && mask_running));
    logic resp_running;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_field <= 1'b0;
        end else begin
            pend_field <= (pend_field || (resp_trig && nfc_mode && !act_mode && !field_now))
                          && !resp_start && !set_def;
        end
    end

    step_counter #(.WIDTH(16)) u_resp (
        .clk     (clk),
        .reset_n (reset_n),
        .start   (resp_start),
        .stop    (resp_stop),
        .step    (resp_step),
        .load    (resp_load),
        .running (resp_running),
        .expired (resp_expired)
    );

    // General purpose timer trigger selection; codes 4..7 start by command only
    logic gen_auto;
    always_comb begin
        case (trig_code)
            3'(rf_timer_pkg::TRIG_RX_END):     gen_auto = frame_ev.rx_end;
            3'(rf_timer_pkg::TRIG_RX_START):   gen_auto = frame_ev.rx_start;
            3'(rf_timer_pkg::TRIG_TX_END_NFC): gen_auto = frame_ev.tx_end && nfc_mode;
            default:                           gen_auto = 1'b0;
        endcase
    end

    wire  gen_step = step_of(fc_div, rf_timer_pkg::FC_GEN_STEP, fc_tick);
    logic gen_running;

    step_counter #(.WIDTH(16)) u_gen (
        .clk     (clk),
        .reset_n (reset_n),
        .start   (cmd_gen || gen_auto),
        .stop    (set_def),
        .step    (gen_step),
        .load    (gen_load),
        .running (gen_running),
        .expired (gen_expired)
    );

    // Field switch-off after general timer in code 3; cleared by set-default or the general timer start command
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            field_off <= 1'b0;
        end else if (gen_expired && trig_code == 3'(rf_timer_pkg::TRIG_TX_END_NFC)) begin
            field_off <= 1'b1;
        end else if (set_def || cmd_gen) begin
            field_off <= 1'b0;
        end
    end

    // Sticky expiry flags, cleared by a status read; a new expiry wins over the clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stat_resp <= 1'b0;
            stat_gen  <= 1'b0;
        end else begin
            stat_resp <= resp_expired || (stat_resp && !stat_rd && !set_def);
            stat_gen  <= gen_expired || (stat_gen && !stat_rd && !set_def);
        end
    end

    wire resp_vis = stat_resp && !irq_mask[rf_timer_pkg::MASK_RESP_BIT];
    wire gen_vis  = stat_gen && !irq_mask[rf_timer_pkg::MASK_GEN_BIT];
    wire tim_sum  = resp_vis || gen_vis;
    assign timer_irq = tim_sum;

    // Read mux
    logic [7:0] rd_val;
    always_comb begin
        case (idx)
            rf_timer_pkg::IDX_RX_MASK_TIME:  rd_val = rx_mask_time;
            rf_timer_pkg::IDX_RESP_HIGH:     rd_val = response_timeout_high;
            rf_timer_pkg::IDX_RESP_LOW:      rd_val = response_timeout_low;
            rf_timer_pkg::IDX_TIMER_CONTROL: rd_val = timer_control;
            rf_timer_pkg::IDX_GEN_HIGH:      rd_val = general_timeout_high;
            rf_timer_pkg::IDX_GEN_LOW:       rd_val = general_timeout_low;
            rf_timer_pkg::IDX_MODE:          rd_val = mode;
            rf_timer_pkg::IDX_IRQ_MASK:      rd_val = irq_mask;
            rf_timer_pkg::IDX_STATUS:        rd_val = {2'h0, gen_running, resp_running, mask_running,
                                                       stat_gen, tim_sum, stat_resp};
            default:                         rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= '0;
        end else if (avs_read && !answered) begin
            avs_readdata <= {24'h000000, rd_val};
        end
    end

    // Checks
    a_mask_blocks_rx: assert property (@(posedge clk) disable iff (!reset_n)
        mask_running |=> !rx_event) else $error("receive event during mask");
    a_zero_no_start: assert property (@(posedge clk) disable iff (!reset_n)
        (resp_load == 16'h0000 && !resp_running) |=> !resp_running) else $error("zero timeout started");
    a_mask_starts_tx: assert property (@(posedge clk) disable iff (!reset_n)
        frame_ev.tx_end && !set_def |=> mask_running) else $error("mask not started");
    a_resp_cmd_start: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_resp && !resp_zero |=> resp_running) else $error("response command ignored");
    a_gen_cmd_start: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_gen && !set_def |=> gen_running) else $error("general command ignored");
    a_reserved_trig: assert property (@(posedge clk) disable iff (!reset_n)
        trig_code[2] |-> !gen_auto) else $error("reserved trigger acted");
    a_irq_masked: assert property (@(posedge clk) disable iff (!reset_n)
        irq_mask[6] && irq_mask[5] |-> !timer_irq) else $error("masked interrupt visible");
    a_expiry_flag: assert property (@(posedge clk) disable iff (!reset_n)
        resp_expired |=> stat_resp) else $error("expiry flag missing");
    a_setdef_loads: assert property (@(posedge clk) disable iff (!reset_n)
        set_def |=> rx_mask_time == 8'h08 && timer_control == 8'h00) else $error("defaults not loaded");
    a_nfc_wait_field: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(resp_running) && nfc_mode && !act_mode |-> $past(field_now) || $past(cmd_resp))
        else $error("response started without field");
endmodule
`default_nettype wire

/* tb/rf_protocol_timers_bench.sv */
// Self-checking bench for the protocol timer block: register access and timer events.
// Assumes one wait state on every Avalon access and fc_tick high each clock (1 fc = 1 cycle).
`default_nettype none
module rf_protocol_timers_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    clk = 1'b0;
    logic                    reset_n = 1'b0;
    logic                    fc_tick = 1'b1;
    rf_timer_pkg::frame_ev_t ev = '0;
    logic [9:0]              avs_address = '0;
    logic                    avs_read = 1'b0;
    logic                    avs_write = 1'b0;
    logic [31:0]             avs_writedata = '0;
    logic [31:0]             avs_readdata;
    logic                    avs_waitrequest, rx_event, resp_expired, gen_expired, timer_irq;
    logic                    field_off;
    int                      mismatches = 0;
    int                      total_checks = 0;
    int                      cycles = 0;
    int                      n;
    logic [7:0]              q;
    rf_protocol_timers i_rf_protocol_timers (.clk(clk), .reset_n(reset_n), .fc_tick(fc_tick), .frame_ev(ev),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rx_event(rx_event), .squelch_on(), .field_off(field_off), .resp_expired(resp_expired),
        .gen_expired(gen_expired), .timer_irq(timer_irq));
    always #4 clk = ~clk;
    // Runaway guard; the whole sequence needs well under this many cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One bus access; waitrequest is sampled at each rising edge until the completing one
    task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] r);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        r = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // Framing pulse of one cycle; the receiver level stays as given
    task automatic pulse(input rf_timer_pkg::frame_ev_t e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= e & 5'h01;
    endtask
    // Cycles until the chosen output rises (0 rx_event, 1 response, 2 general), capped at lim
    task automatic meas(input int sel, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while (cnt < lim && ((sel == 0) ? rx_event : (sel == 1) ? resp_expired : gen_expired) !== 1'b1);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        acc(0, rf_timer_pkg::IDX_RX_MASK_TIME, 0, q); chk(q, 8'h08);
        acc(1, rf_timer_pkg::IDX_RESP_HIGH, 8'h5a, q);
        acc(0, rf_timer_pkg::IDX_RESP_HIGH, 0, q); chk(q, 8'h5a);
        acc(0, 8'h3c, 0, q); chk(q, 8'h00);
        acc(1, rf_timer_pkg::IDX_RX_MASK_TIME, 8'h00, q);
        acc(1, rf_timer_pkg::IDX_COMMAND, rf_timer_pkg::CMD_SET_DEFAULT, q);
        acc(0, rf_timer_pkg::IDX_RX_MASK_TIME, 0, q); chk(q, 8'h08);
        acc(0, rf_timer_pkg::IDX_RESP_HIGH, 0, q); chk(q, 8'h00);
        // Mask value 0 acts as 4 steps; receiver held active throughout the mask
        acc(1, rf_timer_pkg::IDX_RX_MASK_TIME, 8'h00, q);
        pulse(5'h11);
        meas(0, 400, n); chk(n >= 185 && n <= 262, 1);
        pulse(5'h00);
        // Zero timeout must never fire, one step fires within 64 fc
        pulse(5'h10); meas(1, 300, n); chk(n, 300);
        acc(1, rf_timer_pkg::IDX_RESP_LOW, 8'h01, q);
        pulse(5'h10); meas(1, 300, n); chk(n >= 1 && n <= 70, 1);
        // Two long steps: the free prescaler may shorten only the first one
        acc(1, rf_timer_pkg::IDX_RESP_LOW, 8'h02, q);
        acc(1, rf_timer_pkg::IDX_TIMER_CONTROL, 8'h01, q);
        pulse(5'h10); meas(1, 9000, n); chk(n > 4096 && n <= 8200, 1);
        // General timer: command start, start-of-receive trigger, reserved trigger
        acc(1, rf_timer_pkg::IDX_GEN_LOW, 8'h02, q);
        acc(1, rf_timer_pkg::IDX_COMMAND, rf_timer_pkg::CMD_START_GEN, q);
        meas(2, 100, n); chk(n >= 1 && n <= 20, 1);
        @(negedge clk); chk(timer_irq, 1'b1);
        acc(1, rf_timer_pkg::IDX_TIMER_CONTROL, 8'h40, q);
        pulse(5'h08); meas(2, 100, n); chk(n <= 20, 1);
        // Status shows both sticky flags and the summary, and the read clears them
        acc(0, rf_timer_pkg::IDX_STATUS, 0, q); chk(q, 8'h07);
        acc(0, rf_timer_pkg::IDX_STATUS, 0, q); chk(q, 8'h00);
        acc(1, rf_timer_pkg::IDX_TIMER_CONTROL, 8'ha0, q);
        pulse(5'h08); meas(2, 100, n); chk(n, 100);
        // Code 3 in NFC mode: end of transmit starts the timer, expiry drops the field
        acc(1, rf_timer_pkg::IDX_MODE, 8'h01, q);
        acc(1, rf_timer_pkg::IDX_TIMER_CONTROL, 8'h60, q);
        chk(field_off, 1'b0);
        pulse(5'h10); meas(2, 100, n); chk(n <= 20, 1);
        @(negedge clk); chk(field_off, 1'b1);
        report_and_stop();
    end
endmodule
`default_nettype wire
